// >>> hdl/axseq_cfg.svh
// constants for the auxiliary input acquisition sequencer
`ifndef AXSEQ_CFG_SVH
`define AXSEQ_CFG_SVH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define AXSEQ_CLK_NS 100
`define AXSEQ_STEP_NS 5300
`define AXSEQ_MAXDLY_NS 339200
`define AXSEQ_CONV1_NS 10000
`define AXSEQ_CONV2_NS 7000
`define AXSEQ_STEP_CYC ((`AXSEQ_STEP_NS + `AXSEQ_CLK_NS - 1) / `AXSEQ_CLK_NS)
`define AXSEQ_CONV1_CYC (`AXSEQ_CONV1_NS / `AXSEQ_CLK_NS)
`define AXSEQ_CONV2_CYC ((`AXSEQ_CONV2_NS - `AXSEQ_CONV1_NS + `AXSEQ_CONV1_NS) / `AXSEQ_CLK_NS)
// ---------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define AXSEQ_IDX_STATUS 10'h002
`define AXSEQ_IDX_SCAN 10'h004
`define AXSEQ_IDX_CONV_CFG 10'h008
`define AXSEQ_IDX_ACQ_CFG 10'h00c
`define AXSEQ_IDX_THR_COLD 10'h01e
`define AXSEQ_IDX_THR_HOT 10'h01f
`define AXSEQ_IDX_RES1 10'h040
`define AXSEQ_IDX_RES2 10'h041
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define AXSEQ_EN1_BIT 0
`define AXSEQ_EN2_BIT 1
`define AXSEQ_SCAN_BIT 0
`define AXSEQ_DLY_LSB 0
`define AXSEQ_DLY_W 6
`define AXSEQ_RES_LSB 4
`define AXSEQ_HOTEN_BIT 1
`define AXSEQ_COLDEN_BIT 0
`define AXSEQ_ST_BUSY_BIT 0
`define AXSEQ_ST_HOT_BIT 1
`define AXSEQ_ST_COLD_BIT 2
`define AXSEQ_ST_DONE_BIT 3
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define AXSEQ_EN_RST 2'h0
`define AXSEQ_DLY_RST 6'h00
`define AXSEQ_THR_COLD_RST 12'hfff
`define AXSEQ_THR_HOT_RST 12'h000
`endif

// >>> hdl/axseq_pkg.sv
// types and helpers for the auxiliary input acquisition sequencer
`default_nettype none
`include "axseq_cfg.svh"
package axseq_pkg;
  typedef enum logic [1:0] {
    AXSEQ_ST_IDLE   = 2'b00,
    AXSEQ_ST_CELL   = 2'b01,
    AXSEQ_ST_SETTLE = 2'b10,
    AXSEQ_ST_CONV   = 2'b11
  } axseq_state_t;

  typedef logic [11:0] axseq_cyc_t;
  typedef logic [15:0] axseq_word_t;

  // settle code n gives (n+1) steps
  function automatic axseq_cyc_t axseq_settle_cyc(input logic [5:0] code);
    logic [12:0] prod;
    prod = 13'(({7'h00, code} + 13'h0001) * 13'(`AXSEQ_STEP_CYC));
    return prod[11:0];
  endfunction : axseq_settle_cyc

  // byte-lane merge of a 16-bit register
  function automatic axseq_word_t axseq_merge(input axseq_word_t old_v,
                                              input axseq_word_t new_v,
                                              input logic [1:0] strb);
    axseq_word_t m;
    m = {{8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : axseq_merge
endpackage : axseq_pkg
`default_nettype wire

// >>> hdl/axseq_if.sv
// carriers between the sequencer core, its bus slave and its timer
`default_nettype none
interface axseq_reg_if;
  logic        wr_en;
  logic [9:0]  wr_idx;
  logic [15:0] wr_data;
  logic [1:0]  wr_strb;
  logic        wr_ok;
  logic [9:0]  rd_idx;
  logic [15:0] rd_data;
  logic        rd_ok;
  modport slave (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                 input  wr_ok, rd_data, rd_ok);
  modport core  (input  wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                 output wr_ok, rd_data, rd_ok);
endinterface : axseq_reg_if

interface axseq_tmr_if;
  logic        load;
  logic [11:0] val;
  logic        expired;
  modport timer (input load, val, output expired);
  modport user  (output load, val, input expired);
endinterface : axseq_tmr_if
`default_nettype wire

// >>> hdl/axseq_timer.sv
// one-shot cycle down-counter
`default_nettype none
module axseq_timer
  import axseq_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  axseq_tmr_if.timer      tmr
);
  axseq_cyc_t cnt_r;

  // expires in the cycle after val-1 idle cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 12'h000;
    end else if (tmr.load) begin
      cnt_r <= tmr.val;
    end else if (cnt_r != 12'h000) begin
      cnt_r <= cnt_r - 12'h001;
    end
  end

  assign tmr.expired = (cnt_r == 12'h001);
endmodule : axseq_timer
`default_nettype wire

// >>> hdl/axseq_axil.sv
// axi4-lite slave front end for the sequencer registers
`default_nettype none
module axseq_axil
  import axseq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  axseq_reg_if.slave       regs
);
  logic        aw_r;
  logic        w_r;
  logic [9:0]  awidx_r;
  logic [15:0] wdata_r;
  logic [1:0]  wstrb_r;

  assign s_axi_awready = !aw_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign regs.wr_en    = aw_r && w_r;
  assign regs.wr_idx   = awidx_r;
  assign regs.wr_data  = wdata_r;
  assign regs.wr_strb  = wstrb_r;
  assign regs.rd_idx   = s_axi_araddr[11:2];

  // ---------------------------------------------------------------
  // write channels, taken in either order
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r    <= 1'b0;
      w_r     <= 1'b0;
      awidx_r <= 10'h000;
      wdata_r <= 16'h0000;
      wstrb_r <= 2'h0;
    end else if (regs.wr_en) begin
      aw_r <= 1'b0;
      w_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r    <= 1'b1;
        awidx_r <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r     <= 1'b1;
        wdata_r <= s_axi_wdata[15:0];
        wstrb_r <= s_axi_wstrb[1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (regs.wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= regs.wr_ok ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, regs.rd_data};
      s_axi_rresp  <= regs.rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : axseq_axil
`default_nettype wire

// >>> hdl/axseq_top.sv
// auxiliary input acquisition sequencer with its register file
`default_nettype none
`include "axseq_cfg.svh"

module axseq_top
  import axseq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cell_scan_start,
  input  wire logic        cell_scan_done,
  output logic             aux_convert,
  output logic             aux_input_sel,
  input  wire logic [11:0] adc_result,
  output logic             sensor_bias_supply,
  output logic             temp_hot_alert,
  output logic             temp_cold_alert
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  axseq_reg_if regs ();
  axseq_tmr_if tmr ();

  axseq_state_t state_r;
  axseq_state_t state_nxt;
  logic         ch_r;
  logic         ch_nxt;
  logic         first_r;
  logic         bias_r;
  logic         start_r;
  logic         done_r;
  logic         store;
  logic         finish;
  logic         scan_req;
  logic         done_clr;
  logic         tmr_load;
  axseq_cyc_t   tmr_val;

  logic [1:0]   en_r;
  logic [5:0]   dly_r;
  logic [11:0]  thr_cold_r;
  logic [11:0]  thr_hot_r;
  logic [11:0]  res_r [2];
  logic [1:0]   hot_en_r;
  logic [1:0]   cold_en_r;
  logic [1:0]   hot_ch_r;
  logic [1:0]   cold_ch_r;

  axseq_word_t  en_word;
  axseq_word_t  dly_word;
  axseq_word_t  cold_word;
  axseq_word_t  hot_word;
  axseq_word_t  res_word [2];
  axseq_word_t  status_word;
  axseq_word_t  en_new;
  axseq_word_t  dly_new;
  axseq_word_t  cold_new;
  axseq_word_t  hot_new;
  axseq_word_t  res_new [2];

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  axseq_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .regs          (regs.slave)
  );

  axseq_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tmr     (tmr.timer)
  );

  assign tmr.load = tmr_load;
  assign tmr.val  = tmr_val;

  // ---------------------------------------------------------------
  // register views
  // ---------------------------------------------------------------
  assign en_word   = {14'h0000, en_r};
  assign dly_word  = {10'h000, dly_r};
  assign cold_word = {thr_cold_r, 4'h0};
  assign hot_word  = {thr_hot_r, 4'h0};

  always_comb begin
    status_word = 16'h0000;
    status_word[`AXSEQ_ST_BUSY_BIT] = (state_r != AXSEQ_ST_IDLE);
    status_word[`AXSEQ_ST_HOT_BIT]  = |hot_ch_r;
    status_word[`AXSEQ_ST_COLD_BIT] = |cold_ch_r;
    status_word[`AXSEQ_ST_DONE_BIT] = done_r;
  end

  for (genvar i = 0; i < 2; i++) begin : g_res
    always_comb begin
      res_word[i] = {res_r[i], 4'h0};
      res_word[i][`AXSEQ_HOTEN_BIT]  = hot_en_r[i];
      res_word[i][`AXSEQ_COLDEN_BIT] = cold_en_r[i];
    end
    assign res_new[i] = axseq_merge(res_word[i], regs.wr_data, regs.wr_strb);
  end

  assign en_new   = axseq_merge(en_word, regs.wr_data, regs.wr_strb);
  assign dly_new  = axseq_merge(dly_word, regs.wr_data, regs.wr_strb);
  assign cold_new = axseq_merge(cold_word, regs.wr_data, regs.wr_strb);
  assign hot_new  = axseq_merge(hot_word, regs.wr_data, regs.wr_strb);

  // ---------------------------------------------------------------
  // read mux and write decode
  // ---------------------------------------------------------------
  always_comb begin
    regs.rd_ok   = 1'b1;
    regs.rd_data = 16'h0000;
    case (regs.rd_idx)
      `AXSEQ_IDX_STATUS:   regs.rd_data = status_word;
      `AXSEQ_IDX_SCAN:     regs.rd_data = {15'h0000, state_r != AXSEQ_ST_IDLE};
      `AXSEQ_IDX_CONV_CFG: regs.rd_data = en_word;
      `AXSEQ_IDX_ACQ_CFG:  regs.rd_data = dly_word;
      `AXSEQ_IDX_THR_COLD: regs.rd_data = cold_word;
      `AXSEQ_IDX_THR_HOT:  regs.rd_data = hot_word;
      `AXSEQ_IDX_RES1:     regs.rd_data = res_word[0];
      `AXSEQ_IDX_RES2:     regs.rd_data = res_word[1];
      default:             regs.rd_ok   = 1'b0;
    endcase
  end

  always_comb begin
    unique case (regs.wr_idx)
      `AXSEQ_IDX_STATUS, `AXSEQ_IDX_SCAN, `AXSEQ_IDX_CONV_CFG,
      `AXSEQ_IDX_ACQ_CFG, `AXSEQ_IDX_THR_COLD, `AXSEQ_IDX_THR_HOT,
      `AXSEQ_IDX_RES1, `AXSEQ_IDX_RES2: regs.wr_ok = 1'b1;
      default:                          regs.wr_ok = 1'b0;
    endcase
  end

  assign scan_req = regs.wr_en && (regs.wr_idx == `AXSEQ_IDX_SCAN)
                    && regs.wr_strb[0] && regs.wr_data[`AXSEQ_SCAN_BIT];
  assign done_clr = regs.wr_en && (regs.wr_idx == `AXSEQ_IDX_STATUS)
                    && regs.wr_strb[0] && regs.wr_data[`AXSEQ_ST_DONE_BIT];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= `AXSEQ_EN_RST;
    end else if (regs.wr_en && regs.wr_idx == `AXSEQ_IDX_CONV_CFG) begin
      en_r <= en_new[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_r <= `AXSEQ_DLY_RST;
    end else if (regs.wr_en && regs.wr_idx == `AXSEQ_IDX_ACQ_CFG) begin
      dly_r <= dly_new[`AXSEQ_DLY_LSB +: `AXSEQ_DLY_W];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_cold_r <= `AXSEQ_THR_COLD_RST;
      thr_hot_r  <= `AXSEQ_THR_HOT_RST;
    end else if (regs.wr_en) begin
      if (regs.wr_idx == `AXSEQ_IDX_THR_COLD) begin
        thr_cold_r <= cold_new[15:4];
      end
      if (regs.wr_idx == `AXSEQ_IDX_THR_HOT) begin
        thr_hot_r <= hot_new[15:4];
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer decisions
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    ch_nxt    = ch_r;
    tmr_load  = 1'b0;
    tmr_val   = axseq_settle_cyc(dly_r);
    store     = 1'b0;
    finish    = 1'b0;
    unique case (state_r)
      AXSEQ_ST_IDLE: begin
        if (scan_req) begin
          state_nxt = AXSEQ_ST_CELL;
        end
      end
      AXSEQ_ST_CELL: begin
        if (cell_scan_done) begin
          if (en_r[`AXSEQ_EN1_BIT]) begin
            state_nxt = AXSEQ_ST_SETTLE;
            ch_nxt    = 1'b0;
            tmr_load  = 1'b1;
          end else if (en_r[`AXSEQ_EN2_BIT]) begin
            state_nxt = AXSEQ_ST_SETTLE;
            ch_nxt    = 1'b1;
            tmr_load  = 1'b1;
          end else begin
            state_nxt = AXSEQ_ST_IDLE;
            finish    = 1'b1;
          end
        end
      end
      AXSEQ_ST_SETTLE: begin
        if (tmr.expired) begin
          state_nxt = AXSEQ_ST_CONV;
          tmr_load  = 1'b1;
          tmr_val   = first_r ? 12'(`AXSEQ_CONV1_CYC) : 12'(`AXSEQ_CONV2_CYC);
        end
      end
      AXSEQ_ST_CONV: begin
        if (tmr.expired) begin
          store = 1'b1;
          if (!ch_r && en_r[`AXSEQ_EN2_BIT]) begin
            state_nxt = AXSEQ_ST_SETTLE;
            ch_nxt    = 1'b1;
            tmr_load  = 1'b1;
          end else begin
            state_nxt = AXSEQ_ST_IDLE;
            finish    = 1'b1;
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= AXSEQ_ST_IDLE;
      ch_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ch_r    <= ch_nxt;
    end
  end

  // first conversion of the phase gets the longer slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_r <= 1'b0;
    end else if (state_r == AXSEQ_ST_CELL) begin
      first_r <= 1'b1;
    end else if (store) begin
      first_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_r <= 1'b0;
    end else begin
      start_r <= (state_r == AXSEQ_ST_IDLE) && scan_req;
    end
  end

  // bias switch on from the scan request through the cell phase to the scan end, when any auxiliary input is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bias_r <= 1'b0;
    end else if (state_r == AXSEQ_ST_IDLE && scan_req) begin
      bias_r <= |en_r;
    end else if (finish) begin
      bias_r <= 1'b0;
    end
  end

  // scan-done flag, new completion beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_r <= 1'b0;
    end else if (finish) begin
      done_r <= 1'b1;
    end else if (done_clr) begin
      done_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // results, enables and alerts
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_ch
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        res_r[i] <= 12'h000;
      end else if (store && ch_r == 1'(i)) begin
        res_r[i] <= adc_result;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hot_en_r[i]  <= 1'b0;
        cold_en_r[i] <= 1'b0;
      end else if (regs.wr_en && regs.wr_idx == (i == 0 ? `AXSEQ_IDX_RES1
                                                        : `AXSEQ_IDX_RES2)) begin
        hot_en_r[i]  <= res_new[i][`AXSEQ_HOTEN_BIT];
        cold_en_r[i] <= res_new[i][`AXSEQ_COLDEN_BIT];
      end
    end

    // flags follow each new result, set or cleared
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hot_ch_r[i]  <= 1'b0;
        cold_ch_r[i] <= 1'b0;
      end else if (store && ch_r == 1'(i)) begin
        hot_ch_r[i]  <= hot_en_r[i] && (adc_result < thr_hot_r);
        cold_ch_r[i] <= cold_en_r[i] && (adc_result > thr_cold_r);
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign cell_scan_start    = start_r;
  assign aux_convert        = (state_r == AXSEQ_ST_CONV);
  assign aux_input_sel      = ch_r;
  assign sensor_bias_supply = bias_r;
  assign temp_hot_alert     = |hot_ch_r;
  assign temp_cold_alert    = |cold_ch_r;
endmodule : axseq_top
`default_nettype wire

// >>> dv/axseq_far.sv
// far-side model: cell converter and thermistor network
`default_nettype none
module axseq_far (
  input  wire logic        aclk,
  input  wire logic        cell_scan_start,
  output logic             cell_scan_done,
  input  wire logic        aux_convert,
  input  wire logic        aux_input_sel,
  output logic [11:0]      adc_result,
  input  wire logic [11:0] v1,
  input  wire logic [11:0] v2,
  input  wire logic [7:0]  lag
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = -1;
  initial cell_scan_done = 1'h0;
  // done pulse lag+1 cycles after the start request is sampled
  always @(posedge aclk) begin
    cell_scan_done <= (n == 0);
    n <= cell_scan_start ? int'(lag) : ((n >= 0) ? n - 1 : -1);
  end
  // outside a conversion the line carries inverted data
  assign adc_result = aux_convert ? (aux_input_sel ? v2 : v1) : ~(aux_input_sel ? v2 : v1);
endmodule : axseq_far
`default_nettype wire

// >>> dv/axseq_chk_sva.sv
// assertion checker on the sequencer top ports
`default_nettype none
module axseq_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        cell_scan_start,
  input wire logic        cell_scan_done,
  input wire logic        aux_convert,
  input wire logic        aux_input_sel,
  input wire logic        sensor_bias_supply
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic wait_r;
  int   len_r;
  int   gap_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_r <= 1'h0;
      len_r  <= 0;
      gap_r  <= 0;
    end else begin
      wait_r <= cell_scan_start | (wait_r & ~cell_scan_done);
      len_r  <= aux_convert ? len_r + 1 : 0;
      gap_r  <= (cell_scan_done | aux_convert) ? 0 : gap_r + 1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_start; cell_scan_start |=> !cell_scan_start; endproperty
  property p_cell; wait_r |-> !aux_convert; endproperty
  property p_bias_on; $rose(sensor_bias_supply) |-> cell_scan_start; endproperty
  property p_bias_cv; aux_convert |-> sensor_bias_supply; endproperty
  property p_bias_off; $fell(sensor_bias_supply) |-> $fell(aux_convert); endproperty
  property p_settle; $rose(aux_convert) |-> gap_r >= 52 && gap_r <= 3393; endproperty
  property p_len; $fell(aux_convert) |-> len_r == 100 || (len_r == 70 && $past(aux_input_sel));
  endproperty
  property p_sel; aux_convert && $past(aux_convert) |-> $stable(aux_input_sel); endproperty
  property p_rd; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_start: assert property (p_start) else $error("start pulse too long");
  a_cell: assert property (p_cell) else $error("convert in cell phase");
  a_bias_on: assert property (p_bias_on) else $error("bias not on scan");
  a_bias_cv: assert property (p_bias_cv) else $error("convert without bias");
  a_bias_off: assert property (p_bias_off) else $error("bias off early");
  a_settle: assert property (p_settle) else $error("settle length");
  a_len: assert property (p_len) else $error("window length");
  a_sel: assert property (p_sel) else $error("input switched");
  a_rd: assert property (p_rd) else $error("read data moved");
  c_two: cover property ($fell(aux_convert) && len_r == 70);
  c_bias: cover property ($rose(sensor_bias_supply));
  c_cv: cover property ($rose(aux_convert) && aux_input_sel);
endmodule : axseq_chk
bind axseq_top axseq_chk u_chk (.aclk, .aresetn, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .cell_scan_start, .cell_scan_done, .aux_convert, .aux_input_sel, .sensor_bias_supply);
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the sequencer
`default_nettype none
module tb_top;
  import axseq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, cell_scan_start, cell_scan_done, aux_convert, aux_input_sel;
  logic        sensor_bias_supply, temp_hot_alert, temp_cold_alert;
  logic [11:0] s_axi_awaddr, s_axi_araddr, adc_result, v1, v2;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, s;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ena, hf, cf;
  logic [7:0]  lag;
  int          err_count, comparisons, res[2], code, k;
  axseq_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cell_scan_start, .cell_scan_done, .aux_convert, .aux_input_sel, .adc_result,
    .sensor_bias_supply, .temp_hot_alert, .temp_cold_alert);
  axseq_far far (.aclk, .cell_scan_start, .cell_scan_done, .aux_convert, .aux_input_sel,
    .adc_result, .v1, .v2, .lag);
  always #50 aclk = ~aclk;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task end_sim;
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 9000) begin
      err_count++;
      end_sim();
    end
  endtask : step
  task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic pa, pw;
    n = 0;
    pa = 1'h1;
    pw = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (pa | pw) begin
      step(n);
      if (pa & s_axi_awready) begin
        pa = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (pw & s_axi_wready) begin
        pw = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    s_axi_bready <= 1'h1;
    do step(n); while (s_axi_bvalid !== 1'h1);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'h0;
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do step(n); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    // one cycle of backpressure on the read answer
    step(n);
    s_axi_rready <= 1'h1;
    do step(n); while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'h0;
  endtask : rd
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, hf, cf} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, v1, v2, lag} = '0;
    s_axi_wstrb = 4'hf;
    s = 32'd79374;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(12'h020, d, 2'h0);
    chk(d, 32'h0);
    rd(12'h030, d, 2'h0);
    chk(d, 32'h0);
    rd(12'h078, d, 2'h0);
    chk(d, 32'hfff0);
    rd(12'hffc, d, 2'h2);
    wr(12'h078, 32'h8000, 2'h0);
    wr(12'h07c, 32'h4000, 2'h0);
    wr(12'h100, 32'h3, 2'h0);
    wr(12'h104, 32'h3, 2'h0);
    res = '{3, 3};
    for (int i = 0; i < 6; i++) begin
      s = xs(s);
      ena = i[1:0];
      code = (i == 3) ? 63 : int'(s[29:24]);
      v1 <= s[11:0];
      v2 <= s[23:12];
      lag <= {4'h0, s[31:28]};
      wr(12'h020, {30'h0, ena}, 2'h0);
      wr(12'h030, 32'(code), 2'h0);
      rd(12'h030, d, 2'h0);
      chk(d, 32'(code));
      wr(12'h010, 32'h1, 2'h0);
      k = 0;
      do begin
        rd(12'h008, d, 2'h0);
        k++;
      end while (d[0] && k < 5000);
      chk(d[0], 1'h0);
      for (int c = 0; c < 2; c++) begin
        if (ena[c]) begin
          res[c] = (int'(c ? s[23:12] : s[11:0]) << 4) | (res[c] & 3);
          hf[c] = (res[c] >> 4) < 'h400;
          cf[c] = (res[c] >> 4) > 'h800;
        end
      end
      rd(12'h100, d, 2'h0);
      chk(d, 32'(res[0]));
      rd(12'h104, d, 2'h0);
      chk(d, 32'(res[1]));
      chk(temp_hot_alert, |hf);
      chk(temp_cold_alert, |cf);
      chk(sensor_bias_supply, 1'h0);
    end
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
